// [core/usb_port_cfg.svh]
`ifndef USB_PORT_CFG_SVH
`define USB_PORT_CFG_SVH

// Device register byte offsets
`define OFS_FRAME 8'h00
`define OFS_GLOBAL 8'h04
`define OFS_FADDR 8'h08
`define OFS_IRQ_EN 8'h10
`define OFS_IRQ_DIS 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_IRQ_STAT 8'h1C
`define OFS_IRQ_CLR 8'h20
`define OFS_EP_RESET 8'h28
`define OFS_EP_CSR 8'h30
`define OFS_EP_FIFO 8'h50
`define OFS_EP_STRIDE 8'h04
`define OFS_XCVR 8'h74

// Field positions
`define FRAME_ERR_BIT 16
`define FRAME_OK_BIT 17
`define ADDRESSED_BIT 0
`define CONFIGURED_BIT 1
`define FEN_BIT 8
`define XCVR_OFF_BIT 8
`define IRQ_SUSPEND_BIT 8
`define IRQ_RESUME_BIT 9
`define IRQ_SOF_BIT 11
`define IRQ_BUSRES_BIT 12
`define IRQ_WAKEUP_BIT 13
`define IRQ_USED_MASK 32'h00002B0F

// Reset values
`define FADDR_RESET 32'h00000100
`define IRQ_MASK_RESET 32'h00001200

// Controller register offsets
`define CTL_OFS_CTRL 8'h00
`define CTL_OFS_TARGET 8'h04
`define CTL_OFS_DATA 8'h08
`define CTL_OFS_GO 8'h0C
`define CTL_OFS_STATUS 8'h10

// Controller command codes
`define CMD_WRITE 3'h1
`define CMD_READ 3'h2
`define CMD_SET_ADDR 3'h3
`define CMD_SET_CFG 3'h4
`define CMD_FUNC_EN 3'h5

// Cycles the port clock must run before the first access
`define CLK_SETTLE_CYC 4

`endif

// [core/usb_port_pkg.sv]
package usb_port_pkg;

    typedef enum logic [3:0] {
        C_IDLE,
        C_SETTLE,
        C_WRITE,
        C_READ,
        C_READ_WAIT,
        C_ADDR_WR,
        C_STATE_WR,
        C_CFG_RD,
        C_CFG_WAIT,
        C_CFG_WR
    } ctrl_state_t;

    typedef logic [31:0] word_t;

endpackage : usb_port_pkg

// [core/usb_port_if.sv]
`timescale 1ns/100ps
interface usb_port_if;
    logic pclkEn;
    logic [7:0] regAddr;
    logic [31:0] regWdata;
    logic regWr;
    logic regRd;
    logic [31:0] regRdata;

    modport device (
        input pclkEn,
        input regAddr,
        input regWdata,
        input regWr,
        input regRd,
        output regRdata
    );

    modport ctrl (
        output pclkEn,
        output regAddr,
        output regWdata,
        output regWr,
        output regRd,
        input regRdata
    );
endinterface : usb_port_if

// [core/usb_port_dev.sv]
// Operation
// - Port clock enabled before any register access
// - Endpoint CSRs at 0x30, FIFOs 0x50, stride four
// - Frame number captured at SOF packet end
// - Frame error set at bad SOF end
// - Frame good set at clean SOF end
// - SOF status raised at SEEN_A
// - Function address reads zero after reset
// - Interrupt status reset value is unspecified
// - Addressed flag reads device address state
// - Writing zero to addressed flag ignored
// - Load address, finish status, then set addressed
// - Configured flag written and read back directly
// - Configure only when addressed after Set Configuration
// - Program address after Set Address status stage
// - Function enable gates endpoint data traffic
// - Set function enable after host bus reset
// - Interrupt mask bit 12 always reads one
// - Resume mask bit enabled out of reset
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`include "usb_port_cfg.svh"
module usb_port_dev
    import usb_port_pkg::*;
#(
    parameter int EP_COUNT = 4
)
(
    input wire logic clk_sys,
    input wire logic rstn,
    usb_port_if.device bus,
    input wire logic sofPid,
    input wire logic sofEop,
    input wire logic sofErr,
    input wire logic [10:0] sofFrame,
    input wire logic busReset,
    input wire logic suspendEvt,
    input wire logic resumeEvt,
    input wire logic wakeupEvt,
    input wire logic [EP_COUNT-1:0] epIrq,
    input wire logic [7:0] fifoRdata,
    output logic fifoRd,
    output logic fifoWr,
    output logic [1:0] fifoEp,
    output logic [7:0] fifoWdata,
    output logic functionEnable,
    output logic addressedState,
    output logic configuredState,
    output logic [6:0] deviceAddr,
    output logic [EP_COUNT-1:0] epReset,
    output logic transceiverOff,
    output logic irq
);

    logic wrEn;
    logic rdEn;
    logic [10:0] frameIndex_reg;
    logic sofErrorFlag_reg;
    logic sofGoodFlag_reg;
    logic addressed_reg;
    logic configured_reg;
    logic [6:0] funcAddr_reg;
    logic funcEnable_reg;
    word_t irqMask_reg;
    word_t irqStat_reg;
    word_t irqStat_next;
    word_t irqEvents;
    word_t maskView;
    word_t statView;
    logic [EP_COUNT-1:0] epReset_reg;
    logic xcvrOff_reg;
    word_t epCsr_reg [EP_COUNT];
    logic [EP_COUNT-1:0] csrHit;
    logic [EP_COUNT-1:0] fifoHit;
    word_t rdata_reg;
    word_t rdata_next;
    logic fifoWr_reg;
    logic [1:0] fifoEp_reg;
    logic [7:0] fifoWdata_reg;

    // Accesses count only while the port clock is on
    assign wrEn = bus.regWr & bus.pclkEn;
    assign rdEn = bus.regRd & bus.pclkEn;

    genvar g;
    generate
        for (g = 0; g < EP_COUNT; g++)
        begin : gEp
            localparam logic [7:0] CSR_ADDR = 8'(`OFS_EP_CSR + g * `OFS_EP_STRIDE);
            localparam logic [7:0] FIFO_ADDR = 8'(`OFS_EP_FIFO + g * `OFS_EP_STRIDE);
            assign csrHit[g] = (bus.regAddr == CSR_ADDR);
            assign fifoHit[g] = (bus.regAddr == FIFO_ADDR);

            always_ff @(posedge clk_sys or negedge rstn)
            begin
                if (!rstn)
                    epCsr_reg[g] <= 32'h00000000;
                else if (busReset)
                    epCsr_reg[g] <= 32'h00000000;
                else if (wrEn && csrHit[g])
                    epCsr_reg[g] <= bus.regWdata;
            end
        end
    endgenerate

    // Frame capture
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            frameIndex_reg <= 11'h000;
            sofErrorFlag_reg <= 1'b0;
            sofGoodFlag_reg <= 1'b0;
        end
        else if (sofPid)
        begin
            sofErrorFlag_reg <= 1'b0;
            sofGoodFlag_reg <= 1'b0;
        end
        else if (sofEop)
        begin
            frameIndex_reg <= sofFrame;
            sofErrorFlag_reg <= sofErr;
            sofGoodFlag_reg <= ~sofErr;
        end
    end

    // Device state
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            addressed_reg <= 1'b0;
            configured_reg <= 1'b0;
        end
        else if (busReset)
        begin
            addressed_reg <= 1'b0;
            configured_reg <= 1'b0;
        end
        else if (wrEn && bus.regAddr == `OFS_GLOBAL)
        begin
            if (bus.regWdata[`ADDRESSED_BIT])
                addressed_reg <= 1'b1;
            configured_reg <= bus.regWdata[`CONFIGURED_BIT];
        end
    end

    // Function address and enable
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            funcAddr_reg <= 7'h00;
            funcEnable_reg <= 1'(`FADDR_RESET >> `FEN_BIT);
        end
        else if (busReset)
            funcAddr_reg <= 7'h00;
        else if (wrEn && bus.regAddr == `OFS_FADDR)
        begin
            funcAddr_reg <= bus.regWdata[6:0];
            funcEnable_reg <= bus.regWdata[`FEN_BIT];
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            irqMask_reg <= `IRQ_MASK_RESET;
        else if (busReset)
            irqMask_reg <= `IRQ_MASK_RESET;
        else if (wrEn && bus.regAddr == `OFS_IRQ_EN)
            irqMask_reg <= irqMask_reg | (bus.regWdata & `IRQ_USED_MASK);
        else if (wrEn && bus.regAddr == `OFS_IRQ_DIS)
            irqMask_reg <= irqMask_reg & ~(bus.regWdata & `IRQ_USED_MASK);
    end

    always_comb
    begin
        irqEvents = 32'h00000000;
        irqEvents[`IRQ_SUSPEND_BIT] = suspendEvt;
        irqEvents[`IRQ_RESUME_BIT] = resumeEvt;
        irqEvents[`IRQ_SOF_BIT] = sofPid;
        irqEvents[`IRQ_BUSRES_BIT] = busReset;
        irqEvents[`IRQ_WAKEUP_BIT] = wakeupEvt;
        irqStat_next = irqStat_reg;
        if (wrEn && bus.regAddr == `OFS_IRQ_CLR)
            irqStat_next = irqStat_reg & ~bus.regWdata;
        // New events win over a clear in the same cycle
        irqStat_next = irqStat_next | irqEvents;
    end

    // Sticky status; its reset content is not promised to software
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            irqStat_reg <= 32'h00000000;
        else
            irqStat_reg <= irqStat_next;
    end

    always_comb
    begin
        maskView = irqMask_reg;
        maskView[`IRQ_BUSRES_BIT] = 1'b1;
        statView = irqStat_reg & `IRQ_USED_MASK;
        statView[EP_COUNT-1:0] = epIrq;
    end

    assign irq = |(statView & maskView);

    // Endpoint reset and transceiver control
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            epReset_reg <= '0;
            xcvrOff_reg <= 1'b0;
        end
        else if (wrEn && bus.regAddr == `OFS_EP_RESET)
            epReset_reg <= bus.regWdata[EP_COUNT-1:0];
        else if (wrEn && bus.regAddr == `OFS_XCVR)
            xcvrOff_reg <= bus.regWdata[`XCVR_OFF_BIT];
    end

    // FIFO write strobe
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            fifoWr_reg <= 1'b0;
            fifoEp_reg <= 2'h0;
            fifoWdata_reg <= 8'h00;
        end
        else
        begin
            fifoWr_reg <= wrEn && (|fifoHit) && funcEnable_reg;
            if (wrEn && (|fifoHit))
                fifoWdata_reg <= bus.regWdata[7:0];
            for (int i = 0; i < EP_COUNT; i++)
            begin
                if (fifoHit[i] && (wrEn || rdEn))
                    fifoEp_reg <= 2'(i);
            end
        end
    end

    assign fifoRd = rdEn && (|fifoHit) && funcEnable_reg;

    always_comb
    begin
        rdata_next = 32'h00000000;
        case (bus.regAddr)
            `OFS_FRAME:
            begin
                rdata_next[10:0] = frameIndex_reg;
                rdata_next[`FRAME_ERR_BIT] = sofErrorFlag_reg;
                rdata_next[`FRAME_OK_BIT] = sofGoodFlag_reg;
            end
            `OFS_GLOBAL:
            begin
                rdata_next[`ADDRESSED_BIT] = addressed_reg;
                rdata_next[`CONFIGURED_BIT] = configured_reg;
            end
            `OFS_FADDR:
            begin
                rdata_next[6:0] = funcAddr_reg;
                rdata_next[`FEN_BIT] = funcEnable_reg;
            end
            `OFS_IRQ_MASK: rdata_next = maskView;
            `OFS_IRQ_STAT: rdata_next = statView;
            `OFS_EP_RESET: rdata_next[EP_COUNT-1:0] = epReset_reg;
            `OFS_XCVR: rdata_next[`XCVR_OFF_BIT] = xcvrOff_reg;
            default:
            begin
                for (int i = 0; i < EP_COUNT; i++)
                begin
                    if (csrHit[i])
                        rdata_next = epCsr_reg[i];
                    if (fifoHit[i])
                        rdata_next = {24'h000000, fifoRdata};
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rdata_reg <= 32'h00000000;
        else if (rdEn)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= 32'h00000000;
    end

    assign bus.regRdata = rdata_reg;
    assign fifoWr = fifoWr_reg;
    assign fifoEp = fifoEp_reg;
    assign fifoWdata = fifoWdata_reg;
    assign functionEnable = funcEnable_reg;
    assign addressedState = addressed_reg;
    assign configuredState = configured_reg;
    assign deviceAddr = funcAddr_reg;
    assign epReset = epReset_reg;
    assign transceiverOff = xcvrOff_reg;

endmodule : usb_port_dev

// [core/usb_port_ctrl.sv]
`timescale 1ns/100ps
`include "usb_port_cfg.svh"
module usb_port_ctrl
    import usb_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    usb_port_if.ctrl bus,
    input wire logic [7:0] cmdAddr,
    input wire logic [31:0] cmdWdata,
    input wire logic cmdWr,
    input wire logic cmdRd,
    output logic [31:0] cmdRdata
);

    ctrl_state_t state_reg;
    logic clockOn_reg;
    logic [7:0] settle_reg;
    logic [7:0] target_reg;
    word_t data_reg;
    logic busy;
    logic refused_reg;
    logic done_reg;
    logic goWr;
    logic [7:0] busAddr_reg;
    word_t busWdata_reg;
    logic busWr_reg;
    logic busRd_reg;
    word_t cmdRdata_reg;

    assign busy = (state_reg != C_IDLE);
    assign goWr = cmdWr && (cmdAddr == `CTL_OFS_GO) && !busy;

    // Port clock enable and settle time before access
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            clockOn_reg <= 1'b0;
            settle_reg <= 8'h00;
        end
        else
        begin
            if (cmdWr && cmdAddr == `CTL_OFS_CTRL && !busy)
                clockOn_reg <= cmdWdata[0];
            if (!clockOn_reg)
                settle_reg <= 8'h00;
            else if (settle_reg != 8'(`CLK_SETTLE_CYC))
                settle_reg <= settle_reg + 8'h01;
        end
    end

    // Sequencer and bus strobes
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= C_IDLE;
            busAddr_reg <= 8'h00;
            busWdata_reg <= 32'h00000000;
            busWr_reg <= 1'b0;
            busRd_reg <= 1'b0;
            refused_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            busWr_reg <= 1'b0;
            busRd_reg <= 1'b0;
            case (state_reg)
                C_IDLE:
                begin
                    if (goWr)
                    begin
                        done_reg <= 1'b0;
                        refused_reg <= 1'b0;
                        if (!clockOn_reg)
                            refused_reg <= 1'b1;
                        else
                            state_reg <= C_SETTLE;
                    end
                end
                C_SETTLE:
                begin
                    if (settle_reg == 8'(`CLK_SETTLE_CYC))
                    begin
                        case (data_reg[31:29])
                            `CMD_WRITE:
                            begin
                                busAddr_reg <= target_reg;
                                busWdata_reg <= {3'h0, data_reg[28:0]};
                                busWr_reg <= 1'b1;
                                state_reg <= C_WRITE;
                            end
                            `CMD_READ:
                            begin
                                busAddr_reg <= target_reg;
                                busRd_reg <= 1'b1;
                                state_reg <= C_READ;
                            end
                            `CMD_SET_ADDR:
                            begin
                                // Address and enable first, state flag after
                                busAddr_reg <= `OFS_FADDR;
                                busWdata_reg <= `FADDR_RESET | {25'h0, data_reg[6:0]};
                                busWr_reg <= 1'b1;
                                state_reg <= C_ADDR_WR;
                            end
                            `CMD_SET_CFG:
                            begin
                                busAddr_reg <= `OFS_GLOBAL;
                                busRd_reg <= 1'b1;
                                state_reg <= C_CFG_RD;
                            end
                            `CMD_FUNC_EN:
                            begin
                                busAddr_reg <= `OFS_FADDR;
                                busWdata_reg <= `FADDR_RESET;
                                busWr_reg <= 1'b1;
                                state_reg <= C_WRITE;
                            end
                            default:
                            begin
                                refused_reg <= 1'b1;
                                state_reg <= C_IDLE;
                            end
                        endcase
                    end
                end
                C_ADDR_WR:
                begin
                    busAddr_reg <= `OFS_GLOBAL;
                    busWdata_reg <= 32'h00000001 << `ADDRESSED_BIT;
                    busWr_reg <= 1'b1;
                    state_reg <= C_WRITE;
                end
                // Read data stand only in the cycle after the strobe
                C_READ: state_reg <= C_READ_WAIT;
                C_CFG_RD: state_reg <= C_CFG_WAIT;
                C_CFG_WAIT:
                begin
                    if (bus.regRdata[`ADDRESSED_BIT])
                    begin
                        busWdata_reg <= (32'h00000001 << `ADDRESSED_BIT)
                            | (32'h00000001 << `CONFIGURED_BIT);
                        busWr_reg <= 1'b1;
                        state_reg <= C_WRITE;
                    end
                    else
                    begin
                        refused_reg <= 1'b1;
                        state_reg <= C_IDLE;
                    end
                end
                C_READ_WAIT:
                begin
                    done_reg <= 1'b1;
                    state_reg <= C_IDLE;
                end
                C_WRITE:
                begin
                    done_reg <= 1'b1;
                    state_reg <= C_IDLE;
                end
                default: state_reg <= C_IDLE;
            endcase
        end
    end

    // Own registers
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            target_reg <= 8'h00;
            data_reg <= 32'h00000000;
        end
        else if (state_reg == C_READ_WAIT)
            data_reg <= bus.regRdata;
        else if (cmdWr && !busy && cmdAddr == `CTL_OFS_TARGET)
            target_reg <= cmdWdata[7:0];
        else if (cmdWr && !busy && cmdAddr == `CTL_OFS_DATA)
            data_reg <= cmdWdata;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            cmdRdata_reg <= 32'h00000000;
        else if (!cmdRd)
            cmdRdata_reg <= 32'h00000000;
        else
        begin
            case (cmdAddr)
                `CTL_OFS_CTRL: cmdRdata_reg <= {31'h0, clockOn_reg};
                `CTL_OFS_TARGET: cmdRdata_reg <= {24'h0, target_reg};
                `CTL_OFS_DATA: cmdRdata_reg <= data_reg;
                `CTL_OFS_STATUS: cmdRdata_reg <= {29'h0, done_reg, refused_reg, busy};
                default: cmdRdata_reg <= 32'h00000000;
            endcase
        end
    end

    assign cmdRdata = cmdRdata_reg;
    assign bus.pclkEn = clockOn_reg;
    assign bus.regAddr = busAddr_reg;
    assign bus.regWdata = busWdata_reg;
    assign bus.regWr = busWr_reg;
    assign bus.regRd = busRd_reg;

endmodule : usb_port_ctrl

// [verification/usb_port_sva.sv]
`timescale 1ns/100ps
`include "usb_port_cfg.svh"
module usb_port_sva (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic pclkEn,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_rd(logic [7:0] a);
        regRd && pclkEn && regAddr == a;
    endsequence

    sequence s_rd_resv;
        regRd && pclkEn && (regAddr inside {8'h0C, 8'h24, 8'h2C, 8'h70} || regAddr >= 8'h78);
    endsequence

    a_clk_before_access: assert property ((regWr || regRd) |-> pclkEn)
        else $error("register access with port clock off");
    a_strobes_apart: assert property (!(regWr && regRd))
        else $error("read and write strobes together");
    a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data outside its cycle");
    a_resv_zero: assert property (s_rd_resv |=> regRdata == 32'h0)
        else $error("reserved offset read nonzero");
    a_mask_fixed: assert property (s_rd(`OFS_IRQ_MASK) |=> regRdata[12]
        && regRdata[31:14] == 18'h0 && !regRdata[10] && regRdata[7:4] == 4'h0)
        else $error("mask read malformed");
    a_frame_fields: assert property (s_rd(`OFS_FRAME) |=> regRdata[31:18] == 14'h0
        && regRdata[15:11] == 5'h0 && !(regRdata[16] && regRdata[17]))
        else $error("frame read malformed");
    a_global_fields: assert property (s_rd(`OFS_GLOBAL) |=> regRdata[31:2] == 30'h0)
        else $error("global state read malformed");
    a_faddr_fields: assert property (s_rd(`OFS_FADDR) |=> regRdata[31:9] == 23'h0
        && !regRdata[7])
        else $error("function address read malformed");
endmodule : usb_port_sva

// [verification/testbench.sv]
`timescale 1ns/100ps
`include "usb_port_cfg.svh"
module testbench;
    logic clk_sys, rstn, cmdWr, cmdRd, sofPid, sofEop, sofErr, busReset;
    logic suspendEvt, resumeEvt, wakeupEvt, fifoRd, fifoWr, functionEnable;
    logic addressedState, configuredState, transceiverOff, irq;
    logic [7:0] cmdAddr, fifoRdata, fifoWdata;
    logic [31:0] cmdWdata, cmdRdata, v, st;
    logic [10:0] sofFrame;
    logic [3:0] epIrq, epReset;
    logic [1:0] fifoEp;
    logic [6:0] deviceAddr;
    int bad_count, num_checks, wrCount, rdCount;
    logic [7:0] ra [11] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h0C, 8'h24, 8'h30, 8'h40, 8'h70,
        8'h74, 8'h80};
    logic [31:0] re [11] = '{0, 0, 32'h100, 32'h1200, 0, 0, 0, 0, 0, 0, 0};

    usb_port_if link();
    usb_port_dev usb_port_dev_inst (.clk_sys(clk_sys), .rstn(rstn), .bus(link),
        .sofPid(sofPid), .sofEop(sofEop), .sofErr(sofErr), .sofFrame(sofFrame),
        .busReset(busReset), .suspendEvt(suspendEvt), .resumeEvt(resumeEvt),
        .wakeupEvt(wakeupEvt), .epIrq(epIrq), .fifoRdata(fifoRdata), .fifoRd(fifoRd),
        .fifoWr(fifoWr), .fifoEp(fifoEp), .fifoWdata(fifoWdata),
        .functionEnable(functionEnable), .addressedState(addressedState),
        .configuredState(configuredState), .deviceAddr(deviceAddr), .epReset(epReset),
        .transceiverOff(transceiverOff), .irq(irq));
    usb_port_ctrl usb_port_ctrl_inst (.clk_sys(clk_sys), .rstn(rstn), .bus(link),
        .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd),
        .cmdRdata(cmdRdata));
    usb_port_sva usb_port_sva_inst (.clk_sys(clk_sys), .rstn(rstn), .pclkEn(link.pclkEn),
        .regAddr(link.regAddr), .regWdata(link.regWdata), .regWr(link.regWr),
        .regRd(link.regRd), .regRdata(link.regRdata));

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        if (fifoWr === 1'b1) wrCount++;
        if (fifoRd === 1'b1) rdCount++;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task cw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys) {cmdAddr, cmdWdata, cmdWr} <= {a, d, 1'b1};
        @(posedge clk_sys) cmdWr <= 1'b0;
    endtask : cw

    task cr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys) {cmdAddr, cmdRd} <= {a, 1'b1};
        @(posedge clk_sys) cmdRd <= 1'b0;
        #1 d = cmdRdata;
    endtask : cr

    task runCmd(input logic [7:0] t, input logic [31:0] d);
        cw(`CTL_OFS_TARGET, {24'h0, t});
        cw(`CTL_OFS_DATA, d);
        cw(`CTL_OFS_GO, 32'h1);
        st = 32'h0;
        for (int i = 0; i < 60 && st[2] !== 1'b1 && st[1] !== 1'b1; i++)
            cr(`CTL_OFS_STATUS, st);
        // A command that never finishes is a mismatch
        if (st[2] !== 1'b1 && st[1] !== 1'b1)
            bad_count++;
    endtask : runCmd

    task devWr(input logic [7:0] t, input logic [28:0] d);
        runCmd(t, {`CMD_WRITE, d});
    endtask : devWr

    task devRd(input logic [7:0] t, output logic [31:0] d);
        runCmd(t, {`CMD_READ, 29'h0});
        cr(`CTL_OFS_DATA, d);
    endtask : devRd

    task sof(input logic pid, input logic eop, input logic err, input logic [10:0] f);
        @(posedge clk_sys) {sofPid, sofEop, sofErr, sofFrame} <= {pid, eop, err, f};
        @(posedge clk_sys) {sofPid, sofEop} <= 2'b00;
        repeat (2) @(posedge clk_sys);
    endtask : sof

    task conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    initial
    begin
        #1000000;
        bad_count++;
        conclude();
    end

    initial
    begin
        {rstn, cmdWr, cmdRd, sofPid, sofEop, sofErr, busReset} = 7'h0;
        {suspendEvt, resumeEvt, wakeupEvt, epIrq, sofFrame} = 18'h0;
        {cmdAddr, cmdWdata, fifoRdata} = {8'h00, 32'h0, 8'h3C};
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        runCmd(`OFS_FRAME, {`CMD_READ, 29'h0});
        check({31'h0, st[1]}, 32'h1);
        cw(`CTL_OFS_CTRL, 32'h1);
        devWr(8'h0C, 29'h1FFF);
        devWr(`OFS_IRQ_MASK, 29'h0);
        for (int i = 0; i < 11; i++)
        begin
            devRd(ra[i], v);
            check(v, re[i]);
        end
        $display("reset map test done");
        devWr(`OFS_IRQ_CLR, 29'h2B0F);
        sof(1'b1, 1'b0, 1'b0, 11'h0);
        devRd(`OFS_IRQ_STAT, v);
        check(v & 32'h800, 32'h800);
        sof(1'b0, 1'b1, 1'b0, 11'h5A5);
        devRd(`OFS_FRAME, v);
        check(v, 32'h205A5);
        sof(1'b1, 1'b0, 1'b0, 11'h0);
        devRd(`OFS_FRAME, v);
        check(v, 32'h5A5);
        sof(1'b0, 1'b1, 1'b1, 11'h7FF);
        devRd(`OFS_FRAME, v);
        check(v, 32'h107FF);
        $display("frame test done");
        runCmd(8'h0, {`CMD_SET_CFG, 29'h0});
        check({31'h0, st[1]}, 32'h1);
        runCmd(8'h0, {`CMD_SET_ADDR, 29'h55});
        devRd(`OFS_FADDR, v);
        check(v, 32'h155);
        check({24'h0, addressedState, deviceAddr}, 32'hD5);
        devWr(`OFS_GLOBAL, 29'h0);
        devRd(`OFS_GLOBAL, v);
        check(v, 32'h1);
        runCmd(8'h0, {`CMD_SET_CFG, 29'h0});
        devRd(`OFS_GLOBAL, v);
        check(v, 32'h3);
        check({30'h0, configuredState, addressedState}, 32'h3);
        devWr(`OFS_GLOBAL, 29'h1);
        devRd(`OFS_GLOBAL, v);
        check(v, 32'h1);
        @(posedge clk_sys) busReset <= 1'b1;
        @(posedge clk_sys) busReset <= 1'b0;
        devRd(`OFS_GLOBAL, v);
        check(v, 32'h0);
        devRd(`OFS_FADDR, v);
        check(v, 32'h100);
        $display("device state test done");
        devWr(`OFS_IRQ_CLR, 29'h2B0F);
        check({31'h0, irq}, 32'h0);
        @(posedge clk_sys) resumeEvt <= 1'b1;
        @(posedge clk_sys) resumeEvt <= 1'b0;
        #1 check({31'h0, irq}, 32'h1);
        devWr(`OFS_IRQ_CLR, 29'h200);
        check({31'h0, irq}, 32'h0);
        devWr(`OFS_IRQ_EN, 29'h800);
        devRd(`OFS_IRQ_MASK, v);
        check(v, 32'h1A00);
        sof(1'b1, 1'b0, 1'b0, 11'h0);
        check({31'h0, irq}, 32'h1);
        devWr(`OFS_IRQ_DIS, 29'h1800);
        check({31'h0, irq}, 32'h0);
        devRd(`OFS_IRQ_MASK, v);
        check(v, 32'h1200);
        devWr(`OFS_IRQ_EN, 29'h800);
        check({31'h0, irq}, 32'h1);
        devWr(`OFS_IRQ_CLR, 29'h800);
        check({31'h0, irq}, 32'h0);
        $display("interrupt test done");
        devWr(`OFS_FADDR, 29'h0);
        devWr(8'h54, 29'hA5);
        devRd(8'h54, v);
        check({functionEnable, wrCount[14:0], rdCount[15:0]}, 32'h0);
        runCmd(8'h0, {`CMD_FUNC_EN, 29'h0});
        devWr(8'h54, 29'hC3);
        check({22'h0, fifoEp, fifoWdata}, 32'h1C3);
        devRd(8'h58, v);
        check(v, 32'h3C);
        check({functionEnable, wrCount[14:0], rdCount[15:0]}, 32'h80010001);
        devWr(8'h34, 29'h12345);
        devRd(8'h34, v);
        check(v, 32'h12345);
        devRd(8'h30, v);
        check(v, 32'h0);
        devWr(`OFS_EP_RESET, 29'h1FFFFFFF);
        devWr(`OFS_XCVR, 29'h1FFFFFFF);
        devRd(`OFS_EP_RESET, v);
        check(v, 32'hF);
        devRd(`OFS_XCVR, v);
        check(v, 32'h100);
        check({27'h0, transceiverOff, epReset}, 32'h1F);
        $display("endpoint test done");
        conclude();
    end
endmodule : testbench
